// >>> dv/iefs_core_model.sv
`timescale 1ns/10ps
`default_nettype none

// Core sequencer and event sources that sit beside the block
module iefs_core_model (
    // Clock
    input  wire logic        clk,
    // Event sources: timer0, pin, conversion, capcmp, period, timer1
    output logic [5:0]       evt,
    // Stack port
    output logic             stackPush,
    output logic             stackPop,
    output logic [12:0]      pcIn,
    input  wire logic [12:0] pcReturn
);
    // Idle at time zero
    initial begin
        evt = 6'h00;
        stackPush = 1'b0;
        stackPop = 1'b0;
        pcIn = 13'h0aaa;
    end

    // One-cycle pulse from one source
    task automatic fire(input int idx);
        @(posedge clk);
        evt[idx] <= 1'b1;
        @(posedge clk);
        evt <= 6'h00;
    endtask

    // Call or interrupt branch; pc does not linger once taken
    task automatic push(input logic [12:0] pc);
        @(posedge clk);
        stackPush <= 1'b1;
        pcIn <= pc;
        @(posedge clk);
        stackPush <= 1'b0;
        pcIn <= ~pc;
    endtask

    // Return of any kind; value taken at the popping edge
    task automatic pop(output logic [12:0] pc);
        @(posedge clk);
        stackPop <= 1'b1;
        @(posedge clk);
        pc = pcReturn;
        stackPop <= 1'b0;
    endtask
endmodule

`default_nettype wire

// >>> dv/iefs_irq_stack_tb_top.sv
`timescale 1ns/10ps
`default_nettype none

module iefs_irq_stack_tb_top;
    logic        clk = 1'b0, arst_n = 1'b0, psel = 1'b0, penable = 1'b0;
    logic        pwrite = 1'b0, portAcc = 1'b0, err;
    logic        pready, pslverr, coreIrqReq, irq, stackPush, stackPop;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [3:0]  pins = 4'h0, pinIn = 4'h0;
    logic [5:0]  evt;
    logic [12:0] pcIn, pcReturn, pv;
    int          fail_count = 0, total_checks = 0, seed = 32'h015b;
    int          mCtrl = 0, mFlag = 0, mEn = 0, sp = 0, v;
    int          stk[8];

    // Clock of 50 ns period
    always #25 clk = ~clk;

    iefs_irq_stack dut_u (
        .clk, .arst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb(4'hf),
        .prdata, .pready, .pslverr, .timer0Overflow(evt[0]), .extPinEvent(evt[1]),
        .convDoneEvent(evt[2]), .capCmpEvent(evt[3]), .periodMatchEvent(evt[4]),
        .timer1OverflowEvent(evt[5]), .changeDetectPins(pins), .changePinIsInput(pinIn),
        .secondIoPortAccess(portAcc), .stackPush, .stackPop, .pcIn, .pcReturn,
        .coreIrqReq, .irq);
    iefs_core_model core_u (.clk, .evt, .stackPush, .stackPop, .pcIn, .pcReturn);

    // Compare and count
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] %s exp %h seen %h", what, exp, seen);
        end
    endtask

    // Verdict and end of run
    task automatic give_verdict();
        if (fail_count == 0 && total_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // One APB transfer, bounded wait for pready
    task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {2'b00, idx, 2'b00};
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 40);
        if (n >= 40) begin
            fail_count++;
            give_verdict();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Write mirrored in the model
    task automatic wr(input logic [7:0] idx, input int val);
        apb(1'b1, idx, val);
        if (idx == iefs_pkg::IdxCtrlLo || idx == iefs_pkg::IdxCtrlHi) mCtrl = val & 32'hff;
        if (idx == iefs_pkg::IdxPerFlag) mFlag = val & iefs_pkg::PerImplMask;
        if (idx == iefs_pkg::IdxPerEn) mEn = val & iefs_pkg::PerImplMask;
    endtask

    // Read compared with the model; unmapped places read zero
    task automatic rdc(input logic [7:0] idx);
        logic [31:0] e;
        e = 32'h0;
        if (idx == iefs_pkg::IdxCtrlLo || idx == iefs_pkg::IdxCtrlHi) e = mCtrl;
        if (idx == iefs_pkg::IdxPerFlag) e = mFlag;
        if (idx == iefs_pkg::IdxPerEn) e = mEn;
        apb(1'b0, idx, 32'h0);
        check("register", rd, e);
    endtask

    // Request level from model flags and enables
    task automatic reqc();
        logic e;
        @(negedge clk);
        e = mCtrl[7] && ((((mCtrl >> 3) & mCtrl & 7) != 0) || (mCtrl[6] && (mFlag & mEn) != 0));
        check("request", coreIrqReq, e);
    endtask

    // Event from the partner, mirrored in the model flags
    task automatic ev(input int idx);
        core_u.fire(idx);
        if (idx < 2) mCtrl |= 4 >> idx;
        else mFlag |= (idx == 2) ? 32'h40 : 32'h20 >> idx;
    endtask

    // Access pulse on the second port
    task automatic access();
        @(posedge clk);
        portAcc <= 1'b1;
        @(posedge clk);
        portAcc <= 1'b0;
    endtask

    initial begin
        repeat (6) @(posedge clk);
        arst_n <= 1'b1;
        // Reset values, both bank places, one unmapped place
        rdc(iefs_pkg::IdxCtrlHi);
        rdc(iefs_pkg::IdxPerFlag);
        rdc(8'h0d);
        check("error", err, 1'b1);
        wr(iefs_pkg::IdxCtrlHi, $random(seed));
        rdc(iefs_pkg::IdxCtrlLo);
        wr(iefs_pkg::IdxPerEn, $random(seed));
        rdc(iefs_pkg::IdxPerEn);
        // Every source sets its flag with all enables off
        wr(iefs_pkg::IdxCtrlLo, 0);
        wr(iefs_pkg::IdxPerEn, 0);
        for (int i = 0; i < 6; i++) ev(i);
        rdc(iefs_pkg::IdxCtrlLo);
        rdc(iefs_pkg::IdxPerFlag);
        reqc();
        // Flags cleared before enabling; a flag stays until written to zero
        wr(iefs_pkg::IdxPerFlag, 0);
        wr(iefs_pkg::IdxCtrlLo, 32'h38);
        apb(1'b0, iefs_pkg::IdxIrqStat, 32'h0);
        ev(0);
        reqc();
        wr(iefs_pkg::IdxCtrlLo, 32'hbc);
        reqc();
        check("irq", irq, 1'b0);
        apb(1'b0, iefs_pkg::IdxIrqStat, 32'h0);
        check("status", rd, 32'h1);
        wr(iefs_pkg::IdxIrqMask, 1);
        // Peripheral source needs the group enable too
        wr(iefs_pkg::IdxCtrlLo, 32'h80);
        wr(iefs_pkg::IdxPerEn, 32'h04);
        ev(3);
        reqc();
        wr(iefs_pkg::IdxCtrlLo, 32'hc0);
        reqc();
        @(negedge clk);
        check("irq", irq, 1'b1);
        apb(1'b0, iefs_pkg::IdxIrqStat, 32'h0);
        check("status", rd, 32'h1);
        @(negedge clk);
        check("irq", irq, 1'b0);
        wr(iefs_pkg::IdxPerEn, 0);
        reqc();
        // Change flag follows pin mismatch until the port is accessed
        @(posedge clk);
        pinIn <= 4'hf;
        pins <= $random(seed);
        repeat (4) @(posedge clk);
        access();
        wr(iefs_pkg::IdxCtrlLo, 0);
        rdc(iefs_pkg::IdxCtrlLo);
        pins <= pins ^ 4'h4;
        repeat (4) @(posedge clk);
        mCtrl = 1;
        rdc(iefs_pkg::IdxCtrlLo);
        wr(iefs_pkg::IdxCtrlLo, 0);
        mCtrl = 1;
        rdc(iefs_pkg::IdxCtrlLo);
        access();
        wr(iefs_pkg::IdxCtrlLo, 0);
        rdc(iefs_pkg::IdxCtrlLo);
        // Nine pushes wrap over the first; pops return in reverse, circularly
        for (int i = 0; i < 9; i++) begin
            v = $random(seed);
            stk[sp] = v & 32'h1fff;
            core_u.push(v[12:0]);
            sp = (sp + 1) % 8;
        end
        // Wrap recorded in status; top entry readable, pointer not
        wr(iefs_pkg::IdxIrqMask, 2);
        @(negedge clk);
        check("irq", irq, 1'b1);
        apb(1'b0, iefs_pkg::IdxStkTop, 32'h0);
        check("top", rd, stk[(sp + 7) % 8]);
        apb(1'b0, iefs_pkg::IdxIrqStat, 32'h0);
        check("status", rd, 32'h2);
        for (int i = 0; i < 9; i++) begin
            sp = (sp + 7) % 8;
            core_u.pop(pv);
            check("stack", pv, stk[sp]);
        end
        give_verdict();
    end
endmodule

`default_nettype wire

// >>> inc/iefs_pkg.sv
// Shared constants for the interrupt enable, flag and return stack block
package iefs_pkg;

    // Register offsets; printed offsets are not all multiples of four, so they are indices
    localparam logic [7:0] IdxCtrlLo  = 8'h0b;
    localparam logic [7:0] IdxCtrlHi  = 8'h8b;
    localparam logic [7:0] IdxPerFlag = 8'h0c;
    localparam logic [7:0] IdxPerEn   = 8'h8c;
    // Own registers: interrupt status, mask and stack observation
    localparam logic [7:0] IdxIrqStat = 8'hc0;
    localparam logic [7:0] IdxIrqMask = 8'hc1;
    localparam logic [7:0] IdxStkTop  = 8'hc2;

    // Control register bit positions
    localparam int BitGlobalEn  = 7;
    localparam int BitPeriphEn  = 6;
    localparam int BitTmr0En    = 5;
    localparam int BitExtEn     = 4;
    localparam int BitChangeEn  = 3;
    localparam int BitTmr0Flag  = 2;
    localparam int BitExtFlag   = 1;
    localparam int BitChangeFlg = 0;

    // Peripheral bit positions (same in flag and enable registers)
    localparam int BitConvDone  = 6;
    localparam int BitCapCmp    = 2;
    localparam int BitPeriod    = 1;
    localparam int BitTmr1Ovf   = 0;
    localparam logic [7:0] PerImplMask = 8'h47;

    // Reset values
    localparam logic [7:0] CtrlReset  = 8'h00;
    localparam logic [7:0] PerReset   = 8'h00;

    // Stack geometry
    localparam int StackDepth = 8;
    localparam int PcWidth    = 13;

    // Status event bits: 0 core request rose, 1 stack wrapped
    localparam int EvtReq  = 0;
    localparam int EvtWrap = 1;

endpackage

// >>> rtl/iefs_irq_stack.sv
// Implementation choice: the APB register port.
`timescale 1ns/10ps
`default_nettype none

// What this block does
// [RL1] Flags set on source events regardless of enables
// [RL2] Software clears flag before setting its enable
// [RL3] Control register holds three core source pairs
// [RL4] Bit 7 global enable gates all requests
// [RL5] Bit 6 group enable gates peripheral requests
// [RL6] Control register read/write at 0Bh and 8Bh
// [RL7] Register 8Ch holds peripheral enable bits
// [RL8] Register 0Ch holds peripheral flags, same positions
// [RL9] Bit 2 enables capture/compare interrupt
// [RL10] Eight-entry 13-bit hardware return stack
// [RL11] Push PC on call and interrupt branch
// [RL12] Pop on return, literal return, interrupt return
// [RL13] Stack wraps circularly, ninth overwrites first
// [RL14] Stack pointer invisible to software
// [RL15] Push or pop leaves upper PC latch alone
// [RL16] Change flag set by OR of pin mismatches
// [RL17] Port access ends mismatch; flag reasserts meanwhile
// [RL18] Flags stay set until software writes zero
// [RL19] Request is global AND (core OR group peripheral)
module iefs_irq_stack #(
    parameter int Depth = iefs_pkg::StackDepth,
    parameter int PcW   = iefs_pkg::PcWidth
) (
    // Clock and reset
    input  wire logic           clk,
    input  wire logic           arst_n,
    // APB slave
    input  wire logic           psel,
    input  wire logic           penable,
    input  wire logic           pwrite,
    input  wire logic [11:0]    paddr,
    input  wire logic [31:0]    pwdata,
    input  wire logic [3:0]     pstrb,
    output logic      [31:0]    prdata,
    output logic                pready,
    output logic                pslverr,
    // Event sources (same clock, one-cycle pulses)
    input  wire logic           timer0Overflow,
    input  wire logic           extPinEvent,
    input  wire logic           convDoneEvent,
    input  wire logic           capCmpEvent,
    input  wire logic           periodMatchEvent,
    input  wire logic           timer1OverflowEvent,
    // Change-detect pins, compare enable per pin and port access strobe
    input  wire logic [3:0]     changeDetectPins,
    input  wire logic [3:0]     changePinIsInput,
    input  wire logic           secondIoPortAccess,
    // Core sequencer stack port
    input  wire logic           stackPush,
    input  wire logic           stackPop,
    input  wire logic [PcW-1:0] pcIn,
    output logic      [PcW-1:0] pcReturn,
    // Request to the core and system interrupt
    output logic                coreIrqReq,
    output logic                irq
);

    // Pin synchroniser
    logic [3:0] pinMeta_q, pinSync_q;
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            pinMeta_q <= 4'h0;
            pinSync_q <= 4'h0;
        end else begin
            pinMeta_q <= changeDetectPins;
            pinSync_q <= pinMeta_q;
        end
    end

    // APB decode; word index is paddr[9:2]
    logic [7:0] idx;
    logic       wrEn, rdEn, hitCtrl, hitFlag, hitEn, hitStat, hitMask, hitStk, mapped;
    assign idx     = (paddr[11:10] == 2'h0) ? paddr[9:2] : 8'hff; // Upper page hits nothing
    assign wrEn    = psel && penable && pwrite && pstrb[0];
    assign rdEn    = psel && penable && !pwrite;
    assign hitCtrl = (idx == iefs_pkg::IdxCtrlLo) || (idx == iefs_pkg::IdxCtrlHi); // [RL6]
    assign hitFlag = idx == iefs_pkg::IdxPerFlag; // [RL8]
    assign hitEn   = idx == iefs_pkg::IdxPerEn;   // [RL7]
    assign hitStat = idx == iefs_pkg::IdxIrqStat;
    assign hitMask = idx == iefs_pkg::IdxIrqMask;
    assign hitStk  = idx == iefs_pkg::IdxStkTop;
    assign mapped  = hitCtrl || hitFlag || hitEn || hitStat || hitMask || hitStk;
    assign pready  = 1'b1;
    assign pslverr = psel && penable && !mapped;

    // Mismatch latch: pins compared against value captured at last port access
    logic [3:0] oldPins_q, oldPins_d;
    logic       mismatch;
    always_comb begin
        oldPins_d = oldPins_q;
        if (secondIoPortAccess) begin
            oldPins_d = pinSync_q; // [RL17]
        end
    end
    assign mismatch = |((pinSync_q ^ oldPins_q) & changePinIsInput); // [RL16]

    // Control and peripheral registers
    logic [7:0] ctrl_q, ctrl_d, perFlag_q, perFlag_d, perEn_q, perEn_d;
    logic [7:0] perEvt;
    always_comb begin
        perEvt = 8'h00;
        perEvt[iefs_pkg::BitConvDone] = convDoneEvent;
        perEvt[iefs_pkg::BitCapCmp]   = capCmpEvent; // [RL9]
        perEvt[iefs_pkg::BitPeriod]   = periodMatchEvent;
        perEvt[iefs_pkg::BitTmr1Ovf]  = timer1OverflowEvent;
        ctrl_d    = ctrl_q;
        perFlag_d = perFlag_q;
        perEn_d   = perEn_q;
        // Software writes may clear or set flags [RL18]
        if (wrEn && hitCtrl) begin
            ctrl_d = pwdata[7:0]; // [RL3] [RL6]
        end
        if (wrEn && hitFlag) begin
            perFlag_d = pwdata[7:0] & iefs_pkg::PerImplMask;
        end
        if (wrEn && hitEn) begin
            perEn_d = pwdata[7:0] & iefs_pkg::PerImplMask; // [RL7]
        end
        // Hardware set wins over a same-cycle clear, enables ignored [RL1]
        if (timer0Overflow) begin
            ctrl_d[iefs_pkg::BitTmr0Flag] = 1'b1;
        end
        if (extPinEvent) begin
            ctrl_d[iefs_pkg::BitExtFlag] = 1'b1;
        end
        if (mismatch) begin
            ctrl_d[iefs_pkg::BitChangeFlg] = 1'b1; // [RL16] [RL17]
        end
        perFlag_d = perFlag_d | perEvt; // [RL8]
    end

    // Request to core
    logic coreTerm, perTerm, req;
    assign coreTerm = |(ctrl_q[5:3] & ctrl_q[2:0]);
    assign perTerm  = ctrl_q[iefs_pkg::BitPeriphEn] && |(perFlag_q & perEn_q); // [RL5] [RL9]
    assign req      = ctrl_q[iefs_pkg::BitGlobalEn] && (coreTerm || perTerm); // [RL4] [RL19]
    assign coreIrqReq = req;

    // Return stack: circular pointer, never visible to software
    logic [PcW-1:0]           stk_q [Depth];
    logic [PcW-1:0]           stk_d [Depth];
    logic [$clog2(Depth)-1:0] sp_q, sp_d, spDec;
    logic                     wrap;
    logic [$clog2(Depth):0]   fill_q, fill_d;
    assign spDec = sp_q - 1'b1;
    always_comb begin
        stk_d  = stk_q;
        sp_d   = sp_q;
        fill_d = fill_q;
        wrap   = 1'b0;
        if (stackPush) begin
            stk_d[sp_q] = pcIn; // [RL10] [RL11]
            sp_d        = sp_q + 1'b1; // [RL13]
            if (fill_q == ($clog2(Depth)+1)'(Depth)) begin
                wrap = 1'b1;
            end else begin
                fill_d = fill_q + 1'b1;
            end
        end else if (stackPop) begin
            sp_d = spDec; // [RL12] [RL13]
            if (fill_q != '0) begin
                fill_d = fill_q - 1'b1;
            end
        end
    end
    // Popped value offered combinationally from top entry; no upper latch touched [RL15]
    assign pcReturn = stk_q[spDec]; // [RL12]

    // Interrupt status (read clears, set wins) and mask
    logic [1:0] stat_q, stat_d, mask_q, mask_d;
    logic       req_q;
    always_comb begin
        stat_d = stat_q;
        mask_d = mask_q;
        if (rdEn && hitStat) begin
            stat_d = 2'h0;
        end
        if (wrEn && hitMask) begin
            mask_d = pwdata[1:0];
        end
        if (req && !req_q) begin
            stat_d[iefs_pkg::EvtReq] = 1'b1;
        end
        if (wrap) begin
            stat_d[iefs_pkg::EvtWrap] = 1'b1;
        end
    end
    assign irq = |(stat_q & mask_q);

    // Read data mux; stack pointer bits never returned [RL14]
    logic [31:0] rd_d, rd_q;
    always_comb begin
        rd_d = rd_q;
        // Captured in the setup cycle, held through the access phase
        if (psel && !penable) begin
            rd_d = 32'h0;
            if (hitCtrl) begin
                rd_d[7:0] = ctrl_q;
            end else if (hitFlag) begin
                rd_d[7:0] = perFlag_q;
            end else if (hitEn) begin
                rd_d[7:0] = perEn_q;
            end else if (hitStat) begin
                rd_d[1:0] = stat_q;
            end else if (hitMask) begin
                rd_d[1:0] = mask_q;
            end else if (hitStk) begin
                rd_d[PcW-1:0] = stk_q[spDec];
            end
        end
    end
    assign prdata = rd_q;

    // State registers
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ctrl_q    <= iefs_pkg::CtrlReset;
            perFlag_q <= iefs_pkg::PerReset;
            perEn_q   <= iefs_pkg::PerReset;
            oldPins_q <= 4'h0;
            sp_q      <= '0;
            fill_q    <= '0;
            stat_q    <= 2'h0;
            mask_q    <= 2'h0;
            req_q     <= 1'b0;
            rd_q      <= 32'h0;
            for (int i = 0; i < Depth; i++) begin
                stk_q[i] <= '0;
            end
        end else begin
            ctrl_q    <= ctrl_d;
            perFlag_q <= perFlag_d;
            perEn_q   <= perEn_d;
            oldPins_q <= oldPins_d;
            sp_q      <= sp_d;
            fill_q    <= fill_d;
            stat_q    <= stat_d;
            mask_q    <= mask_d;
            req_q     <= req;
            rd_q      <= rd_d;
            stk_q     <= stk_d;
        end
    end

    // Checks
    chk_flag_sets: assert property (@(posedge clk) disable iff (!arst_n) // [RL1]
        capCmpEvent |=> perFlag_q[iefs_pkg::BitCapCmp]) else $error("capcmp flag not set");
    chk_flag_sticky: assert property (@(posedge clk) disable iff (!arst_n) // [RL18]
        $fell(ctrl_q[iefs_pkg::BitTmr0Flag]) |-> $past(wrEn && hitCtrl))
        else $error("timer0 flag cleared without write");
    chk_global_gate: assert property (@(posedge clk) disable iff (!arst_n) // [RL4]
        !ctrl_q[iefs_pkg::BitGlobalEn] |-> !coreIrqReq) else $error("request with global off");
    chk_group_gate: assert property (@(posedge clk) disable iff (!arst_n) // [RL5]
        (!ctrl_q[iefs_pkg::BitPeriphEn] && !coreTerm) |-> !coreIrqReq)
        else $error("peripheral request without group enable");
    chk_capcmp_req: assert property (@(posedge clk) disable iff (!arst_n) // [RL9]
        (ctrl_q[7:6] == 2'h3 && perEn_q[iefs_pkg::BitCapCmp]
         && perFlag_q[iefs_pkg::BitCapCmp]) |-> coreIrqReq) else $error("capcmp request lost");
    chk_push_pop: assert property (@(posedge clk) disable iff (!arst_n) // [RL11]
        (stackPush && !stackPop) ##1 (stackPop && !stackPush) |-> pcReturn == $past(pcIn, 1))
        else $error("pop does not return pushed pc");
    chk_stack_wrap: assert property (@(posedge clk) disable iff (!arst_n) // [RL13]
        stackPush |=> sp_q == $past(sp_q) + 1'b1) else $error("pointer did not advance");
    chk_change_flag: assert property (@(posedge clk) disable iff (!arst_n) // [RL16]
        mismatch |=> ctrl_q[iefs_pkg::BitChangeFlg]) else $error("change flag not set");
    chk_port_access: assert property (@(posedge clk) disable iff (!arst_n) // [RL17]
        secondIoPortAccess |=> oldPins_q == $past(pinSync_q)) else $error("mismatch not ended");

    // Every source sets its own flag, enables ignored
    chk_timer0_count_sets: assert property (@(posedge clk) disable iff (!arst_n) // [RL1]
        timer0Overflow |=> ctrl_q[iefs_pkg::BitTmr0Flag])
        else $error("timer0 flag not set");
    chk_ext_sets: assert property (@(posedge clk) disable iff (!arst_n) // [RL1]
        extPinEvent |=> ctrl_q[iefs_pkg::BitExtFlag])
        else $error("pin flag not set");
    chk_conv_sets: assert property (@(posedge clk) disable iff (!arst_n) // [RL1]
        convDoneEvent |=> perFlag_q[iefs_pkg::BitConvDone])
        else $error("conversion flag not set");
    chk_period_sets: assert property (@(posedge clk) disable iff (!arst_n) // [RL8]
        periodMatchEvent |=> perFlag_q[iefs_pkg::BitPeriod])
        else $error("period flag not set");
    chk_tmr1_sets: assert property (@(posedge clk) disable iff (!arst_n) // [RL8]
        timer1OverflowEvent |=> perFlag_q[iefs_pkg::BitTmr1Ovf])
        else $error("timer1 flag not set");

    // Peripheral flags fall only through a software write
    chk_per_sticky: assert property (@(posedge clk) disable iff (!arst_n) // [RL18]
        $fell(perFlag_q[iefs_pkg::BitCapCmp]) |-> $past(wrEn && hitFlag))
        else $error("capcmp flag cleared without write");

    // Register writes land with the documented masks
    chk_ctrl_write: assert property (@(posedge clk) disable iff (!arst_n) // [RL6]
        (wrEn && hitCtrl && !timer0Overflow && !extPinEvent && !mismatch)
        |=> ctrl_q == $past(pwdata[7:0]))
        else $error("control write lost");
    chk_enable_write: assert property (@(posedge clk) disable iff (!arst_n) // [RL7]
        (wrEn && hitEn) |=> perEn_q == ($past(pwdata[7:0]) & iefs_pkg::PerImplMask))
        else $error("enable write lost");
    chk_perflag_write: assert property (@(posedge clk) disable iff (!arst_n) // [RL8]
        (wrEn && hitFlag && perEvt == 8'h00)
        |=> perFlag_q == ($past(pwdata[7:0]) & iefs_pkg::PerImplMask))
        else $error("flag write lost");

    // Request terms reach the core, masked terms do not
    chk_core_req: assert property (@(posedge clk) disable iff (!arst_n) // [RL19]
        (ctrl_q[iefs_pkg::BitGlobalEn] && ctrl_q[iefs_pkg::BitTmr0En]
         && ctrl_q[iefs_pkg::BitTmr0Flag]) |-> coreIrqReq)
        else $error("timer0 request lost");
    chk_group_pass: assert property (@(posedge clk) disable iff (!arst_n) // [RL5]
        (ctrl_q[7:6] == 2'h3 && |(perFlag_q & perEn_q)) |-> coreIrqReq)
        else $error("peripheral request lost");
    chk_capcmp_mask: assert property (@(posedge clk) disable iff (!arst_n) // [RL9]
        (perEn_q == 8'h00 && !coreTerm) |-> !coreIrqReq)
        else $error("masked peripheral requested");
    chk_stat_rise: assert property (@(posedge clk) disable iff (!arst_n) // [RL19]
        (req && !req_q) |=> stat_q[iefs_pkg::EvtReq])
        else $error("request rise not recorded");

    // Stack port and pointer
    chk_push_top: assert property (@(posedge clk) disable iff (!arst_n) // [RL11]
        stackPush |=> pcReturn == $past(pcIn))
        else $error("pushed pc not on top");
    chk_pop_ptr: assert property (@(posedge clk) disable iff (!arst_n) // [RL12]
        (stackPop && !stackPush) |=> sp_q == $past(spDec))
        else $error("pop did not step back");
    chk_ptr_idle: assert property (@(posedge clk) disable iff (!arst_n) // [RL14]
        (!stackPush && !stackPop) |=> $stable(sp_q))
        else $error("pointer moved without push or pop");
    chk_wrap_flag: assert property (@(posedge clk) disable iff (!arst_n) // [RL13]
        wrap |=> stat_q[iefs_pkg::EvtWrap])
        else $error("wrap not recorded");
    chk_stk_read: assert property (@(posedge clk) disable iff (!arst_n) // [RL14]
        (psel && !penable && hitStk && !stackPush && !stackPop)
        |=> prdata == {{(32-PcW){1'b0}}, pcReturn})
        else $error("top read differs from stack");

    // Port access ends the mismatch while pins hold
    chk_mismatch_end: assert property (@(posedge clk) disable iff (!arst_n) // [RL17]
        (secondIoPortAccess ##1 $stable(pinSync_q)) |-> !mismatch)
        else $error("mismatch outlived port access");

endmodule

`default_nettype wire
